// [rtl/bc_gpio_trigger.sv]
// Back-channel GPIO slot mapping, pin controls and frame trigger source
// Behaviour
// RQ1: Four general-purpose pins, each configurable.
// RQ2: Any slot of any port carries any pin.
// RQ3: One pin may feed many slots.
// RQ4: Any slot may carry the frame trigger.
// RQ5: Slot sources held per port at 0x6E/0x6F.
// RQ6: 0x0E reads current level of every pin; a pin with its input disabled reads 0.
// RQ7: Input paths and pulldowns enabled after reset.
// RQ8: Input enables at 0x0F, pulldowns at 0xBE.
// RQ9: Source 0x8..0xB, generator off: pin forwarded.
// RQ10: Trigger reaches slot only when slot selects it.
// RQ11: Generator enable bit set starts generation.
// RQ12: Tick is one frame: 30 bits of 400 ns.
// RQ13: Enabled generator repeats waveform until disabled.
// RQ14: Source field 7:4; 0x0 means port 0 frame.
// RQ15: Mode bit 1: even duty or separate durations.
// RQ16: Sixteen-bit counts in byte registers 0x19..0x1C.
// RQ17: Bit 2 sets starting level; 0 starts low.
// RQ18: Rate field 2:0 zero selects 2.5 Mbps.
// RQ19: Separate mode: high count, low count, repeat.
// RQ20: Pins synchronized before any slot samples them.
`timescale 1ns/10ps
module bc_gpio_trigger #(
  parameter int PINS = 4,
  parameter int PORTS = 2,
  parameter int SLOTS = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register access from the control bus decoder
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Port page: write mask and read select for per-port registers
  input wire logic [PORTS-1:0] page_wr_mask_i,
  input wire logic [$clog2(PORTS)-1:0] page_rd_sel_i,
  // Pins
  input wire logic [PINS-1:0] gpio_pin_i,
  output logic [PINS-1:0] pin_input_enable_o,
  output logic [PINS-1:0] pin_pulldown_enable_o,
  // Back-channel slots, port major
  output logic [PORTS*SLOTS-1:0] backchannel_slot_o,
  output logic frame_trigger_o
);
  localparam int PSEL_W = $clog2(PORTS);
  localparam int TICK_W_L = gpio_trig_pkg::TICK_W;

  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] pin_sync;
  logic [7:0] input_en;
  logic [7:0] pulldown_en;
  logic [7:0] trig_ctl;
  logic [7:0] high_upper;
  logic [7:0] high_lower;
  logic [7:0] low_upper;
  logic [7:0] low_lower;
  logic [7:0] bc_config [PORTS];
  logic [7:0] slot_src_a [PORTS];
  logic [7:0] slot_src_b [PORTS];
  logic [TICK_W_L-1:0] tick_cnt;
  logic [7:0] next_rdata;
  logic [7:0] pin_level;
  logic [3:0] trig_src;
  logic gen_on;
  logic ext_mode;
  logic ext_level;
  logic [2:0] tick_rate;
  logic [TICK_W_L-1:0] tick_last;
  logic tick;
  logic trigger;
  logic [PORTS*SLOTS-1:0] next_slot;
  logic wr_input_en;
  logic wr_pulldown_en;
  logic wr_trig_ctl;
  logic wr_high_upper;
  logic wr_high_lower;
  logic wr_low_upper;
  logic wr_low_lower;
  logic wr_bc_config;
  logic wr_slot_src_a;
  logic wr_slot_src_b;
  logic gen_was_on;
  logic gen_run;

  trig_gen_if tg ();

  // Frame length in clock cycles for a rate code
  function automatic logic [TICK_W_L-1:0] frame_cycles(input logic [2:0] rate);
    logic [TICK_W_L-1:0] len;
    len = TICK_W_L'(gpio_trig_pkg::TICK_CYCLES);
    if (rate != gpio_trig_pkg::RATE_2P5M) begin
      len = TICK_W_L'(gpio_trig_pkg::TICK_CYCLES);
    end
    return len;
  endfunction : frame_cycles

  // Rate code held in a port's back-channel configuration byte
  function automatic logic [2:0] rate_field(input logic [7:0] cfg);
    return cfg[gpio_trig_pkg::RATE_MSB:gpio_trig_pkg::RATE_LSB];
  endfunction : rate_field

  // Source code decode shared by every slot
  function automatic logic slot_value(input logic [3:0] src, input logic [PINS-1:0] pins,
                                      input logic trig);
    logic v;
    v = 1'b0;
    if (src <= gpio_trig_pkg::SLOT_PIN3) begin
      v = pins[src[1:0]];
    end else if (src == gpio_trig_pkg::SLOT_CONST1) begin
      v = 1'b1;
    end else if (src == gpio_trig_pkg::SLOT_TRIGGER) begin
      v = trig;
    end
    return v;
  endfunction : slot_value

  // Two-stage synchronizer; only the second stage feeds logic
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= gpio_pin_i;
      pin_sync <= pin_meta; // RQ20
    end
  end

  // Disabled input path reads as low, as the buffer would
  assign pin_level = 8'(pin_sync & input_en[PINS-1:0]); // RQ6
  assign pin_input_enable_o = input_en[PINS-1:0]; // RQ7
  assign pin_pulldown_enable_o = pulldown_en[PINS-1:0]; // RQ7

  // Write decode: one strobe per register keeps the flop blocks to plain loads
  assign wr_input_en = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_INPUT_EN;
  assign wr_pulldown_en = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_PULLDOWN_EN;
  assign wr_trig_ctl = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_TRIG_CTL;
  assign wr_high_upper = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_HIGH_UPPER;
  assign wr_high_lower = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_HIGH_LOWER;
  assign wr_low_upper = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_LOW_UPPER;
  assign wr_low_lower = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_LOW_LOWER;
  assign wr_bc_config = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_BC_CONFIG;
  assign wr_slot_src_a = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_SLOT_SRC_A;
  assign wr_slot_src_b = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_SLOT_SRC_B;

  // Global registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      input_en <= gpio_trig_pkg::RST_INPUT_EN; // RQ7
      pulldown_en <= gpio_trig_pkg::RST_PULLDOWN_EN; // RQ7
      trig_ctl <= gpio_trig_pkg::RST_ZERO;
      high_upper <= gpio_trig_pkg::RST_ZERO;
      high_lower <= gpio_trig_pkg::RST_ZERO;
      low_upper <= gpio_trig_pkg::RST_ZERO;
      low_lower <= gpio_trig_pkg::RST_ZERO;
    end else begin
      if (wr_input_en) begin
        input_en <= reg_wdata_i; // RQ8
      end
      if (wr_pulldown_en) begin
        pulldown_en <= reg_wdata_i; // RQ8
      end
      if (wr_trig_ctl) begin
        trig_ctl <= reg_wdata_i;
      end
      if (wr_high_upper) begin
        high_upper <= reg_wdata_i; // RQ16
      end
      if (wr_high_lower) begin
        high_lower <= reg_wdata_i; // RQ16
      end
      if (wr_low_upper) begin
        low_upper <= reg_wdata_i; // RQ16
      end
      if (wr_low_lower) begin
        low_lower <= reg_wdata_i; // RQ16
      end
    end
  end

  // Per-port registers; a write may land on several ports at once
  for (genvar p = 0; p < PORTS; p++) begin : g_port_regs
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        bc_config[p] <= gpio_trig_pkg::RST_ZERO;
        slot_src_a[p] <= gpio_trig_pkg::RST_ZERO;
        slot_src_b[p] <= gpio_trig_pkg::RST_ZERO;
      end else if (page_wr_mask_i[p]) begin
        if (wr_bc_config) begin
          bc_config[p] <= reg_wdata_i; // RQ18
        end
        if (wr_slot_src_a) begin
          slot_src_a[p] <= reg_wdata_i; // RQ5
        end
        if (wr_slot_src_b) begin
          slot_src_b[p] <= reg_wdata_i; // RQ5
        end
      end
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      gpio_trig_pkg::OFS_PIN_LEVEL: next_rdata = pin_level; // RQ6
      gpio_trig_pkg::OFS_INPUT_EN: next_rdata = input_en;
      gpio_trig_pkg::OFS_PULLDOWN_EN: next_rdata = pulldown_en;
      gpio_trig_pkg::OFS_TRIG_CTL: next_rdata = trig_ctl;
      gpio_trig_pkg::OFS_HIGH_UPPER: next_rdata = high_upper;
      gpio_trig_pkg::OFS_HIGH_LOWER: next_rdata = high_lower;
      gpio_trig_pkg::OFS_LOW_UPPER: next_rdata = low_upper;
      gpio_trig_pkg::OFS_LOW_LOWER: next_rdata = low_lower;
      gpio_trig_pkg::OFS_BC_CONFIG: next_rdata = bc_config[page_rd_sel_i];
      gpio_trig_pkg::OFS_SLOT_SRC_A: next_rdata = slot_src_a[page_rd_sel_i];
      gpio_trig_pkg::OFS_SLOT_SRC_B: next_rdata = slot_src_b[page_rd_sel_i];
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data is held until the next read strobe
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Trigger control decode
  assign trig_src = trig_ctl[gpio_trig_pkg::TC_SRC_MSB:gpio_trig_pkg::TC_SRC_LSB]; // RQ14
  assign gen_on = trig_ctl[gpio_trig_pkg::TC_GEN_EN_BIT]; // RQ11
  assign ext_mode = !gen_on && trig_src >= gpio_trig_pkg::SRC_PIN_FIRST
                    && trig_src <= gpio_trig_pkg::SRC_PIN_LAST; // RQ9
  assign ext_level = pin_level[trig_src[1:0]]; // RQ9
  // Source 0x1 follows port 1's frame; anything else follows port 0
  assign tick_rate = (trig_src == gpio_trig_pkg::SRC_PORT1_FRAME && PORTS > 1)
                     ? rate_field(bc_config[PSEL_W'(1)])
                     : rate_field(bc_config[0]); // RQ14
  assign tick_last = frame_cycles(tick_rate) - TICK_W_L'(1); // RQ18
  assign tick = tick_cnt == tick_last;

  // Frame tick counter; free-running so ticks keep frame alignment
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt <= '0;
    end else if (tick || tick_cnt > tick_last) begin
      tick_cnt <= '0; // RQ12
    end else begin
      tick_cnt <= tick_cnt + TICK_W_L'(1);
    end
  end

  // Enable reaches the generator one cycle late: a single write that sets
  // enable and start level together must first preset the new start level
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gen_was_on <= 1'b0;
    end else begin
      gen_was_on <= gen_on;
    end
  end
  assign gen_run = gen_on && gen_was_on; // RQ17

  // Generator hookup
  assign tg.enable = gen_run; // RQ11
  assign tg.duty_even = trig_ctl[gpio_trig_pkg::TC_DUTY_BIT]; // RQ15
  assign tg.start_level = trig_ctl[gpio_trig_pkg::TC_START_BIT]; // RQ17
  assign tg.tick = tick;
  assign tg.high_count = {high_upper, high_lower}; // RQ16
  assign tg.low_count = {low_upper, low_lower}; // RQ16

  trig_gen u_gen (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .tg(tg.gen)
  );

  // Internal generator has priority; its arming cycle and no source give a quiet low
  assign trigger = gen_run ? tg.level : (ext_mode & ext_level); // RQ4

  // Each slot picks its own source; sources may repeat freely
  for (genvar p = 0; p < PORTS; p++) begin : g_slot_port
    for (genvar s = 0; s < SLOTS; s++) begin : g_slot
      logic [3:0] src;
      if (s < 2) begin : g_a
        assign src = slot_src_a[p][s*4 +: 4]; // RQ5
      end else begin : g_b
        assign src = slot_src_b[p][(s-2)*4 +: 4]; // RQ5
      end
      assign next_slot[p*SLOTS+s] = slot_value(src, pin_sync, trigger); // RQ2 RQ3 RQ10
    end
  end

  // Slots and trigger leave from flip-flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      backchannel_slot_o <= '0;
      frame_trigger_o <= 1'b0;
    end else begin
      backchannel_slot_o <= next_slot; // RQ1
      frame_trigger_o <= trigger;
    end
  end
endmodule : bc_gpio_trigger

// [rtl/gpio_trig_pkg.sv]
// Constants for the back-channel GPIO and frame trigger block
package gpio_trig_pkg;
  // Register offsets
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h0E;
  localparam logic [7:0] OFS_INPUT_EN = 8'h0F;
  localparam logic [7:0] OFS_TRIG_CTL = 8'h18;
  localparam logic [7:0] OFS_HIGH_UPPER = 8'h19;
  localparam logic [7:0] OFS_HIGH_LOWER = 8'h1A;
  localparam logic [7:0] OFS_LOW_UPPER = 8'h1B;
  localparam logic [7:0] OFS_LOW_LOWER = 8'h1C;
  localparam logic [7:0] OFS_BC_CONFIG = 8'h58;
  localparam logic [7:0] OFS_SLOT_SRC_A = 8'h6E;
  localparam logic [7:0] OFS_SLOT_SRC_B = 8'h6F;
  localparam logic [7:0] OFS_PULLDOWN_EN = 8'hBE;
  // Reset values
  localparam logic [7:0] RST_INPUT_EN = 8'h0F;
  localparam logic [7:0] RST_PULLDOWN_EN = 8'h0F;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Trigger control fields
  localparam int TC_GEN_EN_BIT = 0;
  localparam int TC_DUTY_BIT = 1;
  localparam int TC_START_BIT = 2;
  localparam int TC_SRC_LSB = 4;
  localparam int TC_SRC_MSB = 7;
  localparam logic [3:0] SRC_PORT0_FRAME = 4'h0;
  localparam logic [3:0] SRC_PORT1_FRAME = 4'h1;
  localparam logic [3:0] SRC_PIN_FIRST = 4'h8;
  localparam logic [3:0] SRC_PIN_LAST = 4'hB;
  // Back-channel rate select field
  localparam int RATE_LSB = 0;
  localparam int RATE_MSB = 2;
  localparam logic [2:0] RATE_2P5M = 3'h0;
  // Slot source codes, four bits per slot
  localparam logic [3:0] SLOT_PIN0 = 4'h0;
  localparam logic [3:0] SLOT_PIN3 = 4'h3;
  localparam logic [3:0] SLOT_CONST0 = 4'h8;
  localparam logic [3:0] SLOT_CONST1 = 4'h9;
  localparam logic [3:0] SLOT_TRIGGER = 4'hA;
  // Generator tick timing
  localparam int FRAME_BITS = 30;
  localparam int BIT_TIME_NS = 400;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_CYCLES = FRAME_BITS * BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 12;
endpackage : gpio_trig_pkg

// [rtl/trig_gen.sv]
// Periodic frame trigger waveform generator counted in frame ticks
`timescale 1ns/10ps
module trig_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control and waveform
  trig_gen_if.gen tg
);
  logic level;
  logic [15:0] remain;
  logic [16:0] period_sum;
  logic [15:0] half_count;
  logic [15:0] dur_high;
  logic [15:0] dur_low;
  logic [15:0] next_load;

  // Even duty splits the programmed total period into two halves
  assign period_sum = {1'b0, tg.high_count} + {1'b0, tg.low_count};
  assign half_count = period_sum[16:1];
  assign dur_high = tg.duty_even ? half_count : tg.high_count;
  assign dur_low = tg.duty_even ? half_count : tg.low_count;
  assign next_load = level ? dur_low : dur_high;
  assign tg.level = level;

  // Disabled holds the start level ready so enabling starts cleanly
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level <= 1'b0;
      remain <= 16'h0000;
    end else if (!tg.enable) begin
      level <= tg.start_level; // RQ17
      remain <= tg.start_level ? dur_high : dur_low;
    end else if (tg.tick) begin
      // A zero count acts as one tick, so the output never stalls
      if (remain <= 16'h0001) begin
        level <= ~level; // RQ19
        remain <= next_load; // RQ13
      end else begin
        remain <= remain - 16'h0001;
      end
    end
  end
endmodule : trig_gen

// [rtl/trig_gen_if.sv]
// Connection between the register side and the trigger generator
`timescale 1ns/10ps
interface trig_gen_if;
  logic enable;
  logic duty_even;
  logic start_level;
  logic tick;
  logic [15:0] high_count;
  logic [15:0] low_count;
  logic level;
  modport ctl (output enable, output duty_even, output start_level, output tick,
               output high_count, output low_count, input level);
  modport gen (input enable, input duty_even, input start_level, input tick,
               input high_count, input low_count, output level);
endinterface : trig_gen_if

// [sim/bc_far_end.sv]
// Far-end serializer model counting pulses received on a back-channel slot
`timescale 1ns/10ps
module bc_far_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Slots arriving over the back channel
  input wire logic [7:0] slot_i,
  output logic [15:0] pulse_count_o
);
  logic last;
  // Only listens; counts rises of port 0 slot 0
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last <= 1'b0;
      pulse_count_o <= 16'h0000;
    end else begin
      last <= slot_i[0];
      if (slot_i[0] && !last) pulse_count_o <= pulse_count_o + 16'h0001;
    end
  end
endmodule : bc_far_end

// [sim/bc_gpio_trigger_chk.sv]
// Assertion checker for the back-channel GPIO and frame trigger block
`timescale 1ns/10ps
module bc_gpio_trigger_chk #(
  parameter int PINS = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Pins and trigger
  input wire logic [PINS-1:0] gpio_pin_i,
  input wire logic [PINS-1:0] pin_input_enable_o,
  input wire logic [PINS-1:0] pin_pulldown_enable_o,
  input wire logic frame_trigger_o
);
  logic [7:0] ctl;
  logic [2:0] age;
  wire ctl_wr = reg_wr_i && reg_addr_i == gpio_trig_pkg::OFS_TRIG_CTL;
  wire ext = age > 3'h3 && !ctl[0] && ctl[7:6] == 2'h2;
  wire idle = age > 3'h1 && !ctl[0] && ctl[7:6] != 2'h2;
  // Shadow of trigger control; age lets the settle checks skip the pipeline
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl <= 8'h00;
      age <= 3'h0;
    end else if (ctl_wr) begin
      ctl <= reg_wdata_i;
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  chk_inen_write: assert property (
    reg_wr_i && reg_addr_i == 8'h0F |=> pin_input_enable_o == $past(reg_wdata_i[PINS-1:0]))
    else $error("input enable differs from write");
  chk_pd_write: assert property (
    reg_wr_i && reg_addr_i == 8'hBE |=> pin_pulldown_enable_o == $past(reg_wdata_i[PINS-1:0]))
    else $error("pulldown enable differs from write");
  chk_level_read: assert property (
    reg_rd_i && reg_addr_i == 8'h0E && gpio_pin_i == $past(gpio_pin_i)
    && gpio_pin_i == $past(gpio_pin_i, 2) && $stable(pin_input_enable_o)
    |=> reg_rdata_o[PINS-1:0] == $past(gpio_pin_i & pin_input_enable_o))
    else $error("pin level readback wrong");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  chk_trig_idle: assert property (idle |-> !frame_trigger_o)
    else $error("trigger active with no source");
  chk_ext_follow: assert property (
    ext && gpio_pin_i == $past(gpio_pin_i) && gpio_pin_i == $past(gpio_pin_i, 2)
    && gpio_pin_i == $past(gpio_pin_i, 3) && pin_input_enable_o == $past(pin_input_enable_o, 3)
    |-> frame_trigger_o == (gpio_pin_i[ctl[5:4]] & pin_input_enable_o[ctl[5:4]]))
    else $error("external trigger does not follow pin");
  chk_start_level: assert property ($rose(ctl[0]) |-> ##[1:2] frame_trigger_o == ctl[2])
    else $error("generator started at wrong level");
  chk_gen_stop: assert property (
    $fell(ctl[0]) && ctl[7:6] != 2'h2 |-> ##[1:2] !frame_trigger_o)
    else $error("trigger kept running after disable");
  cov_ext: cover property (ext && frame_trigger_o);
  cov_gen: cover property (ctl[0] && $rose(frame_trigger_o));
  cov_read: cover property (reg_rd_i && reg_addr_i == 8'h0E);
endmodule : bc_gpio_trigger_chk

bind bc_gpio_trigger bc_gpio_trigger_chk #(.PINS(PINS)) u_chk (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .gpio_pin_i(gpio_pin_i),
  .pin_input_enable_o(pin_input_enable_o),
  .pin_pulldown_enable_o(pin_pulldown_enable_o),
  .frame_trigger_o(frame_trigger_o)
);

// [sim/bc_gpio_trigger_tb.sv]
// Self-checking bench for the back-channel GPIO and frame trigger block
`timescale 1ns/10ps
module bc_gpio_trigger_tb;
  localparam int T = gpio_trig_pkg::TICK_CYCLES;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [1:0] page_wr_mask_i = 2'h0;
  logic [0:0] page_rd_sel_i = 1'h0;
  logic [3:0] gpio_pin_i = 4'h0;
  logic [7:0] reg_rdata_o;
  logic [3:0] pin_input_enable_o;
  logic [3:0] pin_pulldown_enable_o;
  logic [7:0] backchannel_slot_o;
  logic frame_trigger_o;
  logic [15:0] pulses;
  logic [15:0] base;
  int mismatches = 0;
  int check_count = 0;
  bc_gpio_trigger DUT (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .page_wr_mask_i(page_wr_mask_i), .page_rd_sel_i(page_rd_sel_i), .gpio_pin_i(gpio_pin_i),
    .pin_input_enable_o(pin_input_enable_o), .pin_pulldown_enable_o(pin_pulldown_enable_o),
    .backchannel_slot_o(backchannel_slot_o), .frame_trigger_o(frame_trigger_o));
  bc_far_end u_far (.clk_i(clk_i), .resetn_i(resetn_i), .slot_i(backchannel_slot_o),
    .pulse_count_o(pulses));
  // 250 MHz clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic conclude();
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : step
  // Strobes drop for a cycle so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] m);
    reg_addr_i = a;
    reg_wdata_i = d;
    page_wr_mask_i = m;
    reg_wr_i = 1'b1;
    step(1);
    reg_wr_i = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [0:0] s, input logic [7:0] e);
    reg_addr_i = a;
    page_rd_sel_i = s;
    reg_rd_i = 1'b1;
    step(1);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, e);
    step(1);
  endtask : rd
  // Waits for level v, then measures how many cycles it lasts
  task automatic span(input logic v, input int e);
    int k;
    k = 0;
    while (frame_trigger_o !== v && k < 40000) begin
      step(1);
      k++;
    end
    k = 0;
    while (frame_trigger_o === v && k < 40000) begin
      step(1);
      k++;
    end
    chk(16'(k), 16'(e));
  endtask : span
  // Watchdog well beyond the generator runs
  initial begin
    #400000;
    mismatches++;
    conclude();
  end
  initial begin
    step(10);
    resetn_i = 1'b1;
    step(1);
    chk(pin_input_enable_o, 4'hF);
    chk(pin_pulldown_enable_o, 4'hF);
    rd(8'h0F, 1'h0, 8'h0F);
    rd(8'hBE, 1'h0, 8'h0F);
    rd(8'h18, 1'h0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(8'h19 + 8'(i), 1'h0, 8'h00);
      wr(8'h19 + 8'(i), 8'hA5 ^ 8'(i), 2'h0);
      rd(8'h19 + 8'(i), 1'h0, 8'hA5 ^ 8'(i));
    end
    wr(8'h6E, 8'h12, 2'h1);
    wr(8'h6E, 8'h34, 2'h2);
    rd(8'h6E, 1'h0, 8'h12);
    rd(8'h6E, 1'h1, 8'h34);
    wr(8'h20, 8'h5A, 2'h3);
    rd(8'h20, 1'h0, 8'h00);
    wr(8'hBE, 8'h05, 2'h0);
    chk(pin_pulldown_enable_o, 4'h5);
    wr(8'hBE, 8'h0F, 2'h0);
    gpio_pin_i = 4'hA;
    step(3);
    rd(8'h0E, 1'h0, 8'h0A);
    wr(8'h0F, 8'h0D, 2'h0);
    chk(pin_input_enable_o, 4'hD);
    rd(8'h0E, 1'h0, 8'h08);
    wr(8'h0F, 8'h0F, 2'h0);
    for (int p = 0; p < 4; p++) begin
      gpio_pin_i = 4'h0;
      wr(8'h6E, {2{4'(p)}}, 2'h3);
      wr(8'h6F, {2{4'(p)}}, 2'h3);
      gpio_pin_i = 4'h1 << p;
      step(1);
      chk(backchannel_slot_o, 8'h00);
      step(3);
      chk(backchannel_slot_o, 8'hFF);
      gpio_pin_i = ~gpio_pin_i;
      step(4);
      chk(backchannel_slot_o, 8'h00);
    end
    wr(8'h6E, 8'hAA, 2'h1);
    wr(8'h6E, 8'h88, 2'h2);
    wr(8'h6F, 8'h99, 2'h3);
    for (int p = 0; p < 4; p++) begin
      gpio_pin_i = 4'h0;
      wr(8'h18, {4'h8 + 4'(p), 4'h0}, 2'h0);
      gpio_pin_i = 4'h1 << p;
      step(5);
      chk(frame_trigger_o, 1'b1);
      chk(backchannel_slot_o, 8'hCF);
      gpio_pin_i = ~gpio_pin_i;
      step(5);
      chk(frame_trigger_o, 1'b0);
      chk(backchannel_slot_o, 8'hCC);
    end
    gpio_pin_i = 4'h0;
    wr(8'h19, 8'h00, 2'h0);
    wr(8'h1A, 8'h02, 2'h0);
    wr(8'h1B, 8'h00, 2'h0);
    wr(8'h1C, 8'h03, 2'h0);
    wr(8'h58, 8'h00, 2'h3);
    base = pulses;
    wr(8'h18, 8'h01, 2'h0);
    span(1'b1, 2 * T);
    span(1'b0, 3 * T);
    span(1'b1, 2 * T);
    chk(pulses - base, 16'h0002);
    wr(8'h1C, 8'h04, 2'h0);
    wr(8'h18, 8'h03, 2'h0);
    span(1'b1, 3 * T);
    span(1'b0, 3 * T);
    wr(8'h18, 8'h00, 2'h0);
    wr(8'h18, 8'h05, 2'h0);
    step(2);
    chk(frame_trigger_o, 1'b1);
    wr(8'h18, 8'h04, 2'h0);
    step(2);
    chk(frame_trigger_o, 1'b0);
    conclude();
  end
endmodule : bc_gpio_trigger_tb
